// ==== dv/csmm_exec_tb_top.sv ====
`default_nettype none
module csmm_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import csmm_pkg::*;
  logic        core_clk, rst, issue_valid, issue_in_slot, issue_ready;
  logic        mem_req, mem_we, mem_alloc, mem_ack, done, exc_valid;
  logic        reg_wr, reg_rd, irq;
  logic [15:0] issue_opcode;
  logic [31:0] issue_pc, mem_addr, mem_wdata, mem_rdata, pc_out;
  logic [31:0] reg_wdata, reg_rdata, mem_rdv, seen_addr, seen_wdata;
  logic [7:0]  reg_addr;
  logic [3:0]  mem_delay, seen_ctl;
  logic [2:0]  mem_exc, exc_code, mem_fault;
  logic [1:0]  mem_size;
  int          err_count, checks_done;

  csmm_exec u_csmm_exec (.core_clk(core_clk), .rst(rst),
    .issue_valid(issue_valid), .issue_opcode(issue_opcode),
    .issue_pc(issue_pc), .issue_in_slot(issue_in_slot),
    .issue_ready(issue_ready), .mem_req(mem_req), .mem_we(mem_we),
    .mem_size(mem_size), .mem_alloc(mem_alloc), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_exc(mem_exc), .done(done), .exc_valid(exc_valid),
    .exc_code(exc_code), .pc_out(pc_out), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  csmm_mem_model u_csmm_mem_model (.core_clk(core_clk), .rst(rst),
    .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_alloc(mem_alloc), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_exc(mem_exc),
    .delay(mem_delay), .fault(mem_fault), .rd_val(mem_rdv),
    .seen_addr(seen_addr), .seen_wdata(seen_wdata), .seen_ctl(seen_ctl));

  // ----------------------------------------
  // clock, checks and bus tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ga(input int i);
    return OFF_GPR + 8'(4 * i);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic issue(input logic [15:0] op, input logic [31:0] pc,
                       input logic slot);
    int n;
    @(posedge core_clk);
    issue_valid   <= 1'b1;
    issue_opcode  <= op;
    issue_pc      <= pc;
    issue_in_slot <= slot;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (issue_ready !== 1'b1 && n < 200);
    @(posedge core_clk);
    issue_valid <= 1'b0;
  endtask

  task automatic finish_op(output int lat);
    lat = 0;
    do begin
      @(negedge core_clk);
      lat++;
    end while (done !== 1'b1 && exc_valid !== 1'b1 && lat < 200);
  endtask

  task automatic run(input logic [15:0] op, input logic [31:0] pc,
                     input logic slot, output int lat);
    issue(op, pc, slot);
    finish_op(lat);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    int          lat;
    rd(OFF_CTRL, d);
    chk(d, 32'(CTRL_RST));
    rd(8'h3c, d);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    run(16'hf000, 32'h7000, 1'b0, lat);
    chk(pc_out, 32'h0000_7002);
    rd(OFF_STATUS, d);
    chk(d & 32'h8, 32'h8);
  endtask

  task automatic t_moves();
    logic [15:0] op [7] = '{16'h8010, 16'h801f, 16'h811f, 16'h113f,
                            16'h841f, 16'h851f, 16'h551f};
    logic [31:0] ad [7] = '{32'h1000, 32'h100f, 32'h101e, 32'h103c,
                            32'h100f, 32'h101e, 32'h103c};
    logic [3:0]  ct [7] = '{4'h8, 4'h8, 4'h9, 4'ha, 4'h0, 4'h1, 4'h2};
    logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h5a5a_5a80,
                            32'h5a5a_8001, 32'h1234_5670};
    int          dr [7] = '{0, 0, 0, 0, 0, 0, 5};
    logic [31:0] ev [7] = '{32'ha5b6_c7d8, 32'ha5b6_c7d8, 32'ha5b6_c7d8,
                            32'h0bad_f00d, 32'hffff_ff80, 32'hffff_8001,
                            32'h1234_5670};
    logic [31:0] d;
    int          lat;
    wr(ga(0), 32'ha5b6_c7d8);
    wr(ga(1), 32'h0000_1000);
    wr(ga(3), 32'h0bad_f00d);
    for (int i = 0; i < 7; i++) begin
      mem_delay = 4'(i % 3);
      mem_rdv   = rv[i];
      run(op[i], 32'h2000 + 32'(2 * i), 1'b0, lat);
      chk(seen_addr, ad[i]);
      chk(32'(seen_ctl), 32'(ct[i]));
      if (ct[i][3]) begin
        chk(seen_wdata, ev[i]);
      end else begin
        rd(ga(dr[i]), d);
        chk(d, ev[i]);
      end
      chk(pc_out, 32'h2002 + 32'(2 * i));
    end
  endtask

  task automatic t_interlock();
    logic [31:0] d;
    int          lat;
    wr(ga(1), 32'h0000_0003);
    mem_delay = 4'h5;
    mem_rdv   = 32'h5a5a_5a81;
    issue(16'h8410, 32'h3000, 1'b0);
    issue(16'h0107, 32'h3002, 1'b0);
    finish_op(lat);
    rd(OFF_MUL_LO, d);
    chk(d, 32'hffff_fe83);
    mem_delay = 4'h0;
  endtask

  task automatic t_addr_load();
    logic [31:0] d;
    int          lat;
    run(16'hc702, 32'h0000_1006, 1'b0, lat);
    chk(32'(lat), 32'h1);
    rd(ga(0), d);
    chk(d, 32'h0000_1010);
    chk(pc_out, 32'h0000_1008);
    wr(OFF_MASK, 32'h0);
    wr(OFF_STATUS, 32'hf);
    run(16'hc7ff, 32'h0000_1100, 1'b1, lat);
    chk(32'(exc_valid), 32'h1);
    chk(32'(exc_code), 32'(EXC_SLOT));
    rd(ga(0), d);
    chk(d, 32'h0000_1010);
    chk(pc_out, 32'h0000_1008);
    chk(32'(irq), 32'h0);
    wr(OFF_MASK, 32'h1 << EV_SLOT);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(irq), 32'h1);
    wr(OFF_STATUS, 32'h1 << EV_SLOT);
    repeat (2) @(posedge core_clk);
    #1 chk(32'(irq), 32'h0);
  endtask

  task automatic t_alloc_store();
    int lat;
    wr(ga(0), 32'h1122_3344);
    wr(ga(2), 32'h0000_2000);
    run(16'h02c3, 32'h4000, 1'b0, lat);
    chk(seen_addr, 32'h0000_2000);
    chk(seen_wdata, 32'h1122_3344);
    chk(32'(seen_ctl), 32'he);
    for (int i = 1; i < 5; i++) begin
      mem_fault = 3'(i);
      run(16'h02c3, 32'h4100, 1'b0, lat);
      chk(32'(exc_code), 32'(i));
      chk(pc_out, 32'h0000_4002);
    end
    mem_fault = 3'h0;
  endtask

  task automatic t_flag();
    logic [31:0] d;
    int          lat;
    for (int t = 0; t < 2; t++) begin
      wr(OFF_CTRL, 32'h1 | 32'(t << 1));
      wr(ga(4), 32'h5);
      run(16'h0429, 32'h5000, 1'b0, lat);
      rd(ga(4), d);
      chk(d, 32'(t));
      rd(OFF_CTRL, d);
      chk(d, 32'h1 | 32'(t << 1));
    end
  endtask

  task automatic t_mul();
    logic [31:0] d;
    int          lat;
    wr(OFF_MUL_HI, 32'h1234_5678);
    wr(ga(6), 32'hffff_fffe);
    wr(ga(7), 32'h0000_5555);
    run(16'h0677, 32'h6000, 1'b0, lat);
    chk(32'(lat), 32'(MUL_LONG_STATES));
    rd(OFF_MUL_LO, d);
    chk(d, 32'hffff_5556);
    wr(ga(6), 32'h1234_fffe);
    wr(ga(7), 32'habcd_5555);
    run(16'h267f, 32'h6002, 1'b0, lat);
    chk(32'(lat), 32'(MUL_WORD_STATES));
    rd(OFF_MUL_LO, d);
    chk(d, 32'hffff_5556);
    rd(OFF_MUL_HI, d);
    chk(d, 32'h1234_5678);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    {rst, issue_valid, issue_in_slot, reg_wr, reg_rd} = 5'h10;
    {issue_opcode, issue_pc, reg_addr, reg_wdata} = '0;
    {mem_delay, mem_fault, mem_rdv} = '0;
    err_count   = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_moves();
    t_interlock();
    t_addr_load();
    t_alloc_store();
    t_flag();
    t_mul();
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// ==== dv/csmm_mem_model.sv ====
`default_nettype none
module csmm_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_size,
  input  wire logic        mem_alloc,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic [2:0]       mem_exc,
  input  wire logic [3:0]  delay,
  input  wire logic [2:0]  fault,
  input  wire logic [31:0] rd_val,
  output logic [31:0]      seen_addr,
  output logic [31:0]      seen_wdata,
  output logic [3:0]       seen_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // ----------------------------------------
  // one request at a time, answered after delay
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_exc   <= 3'h7;
      mem_rdata <= 32'hffff_ffff;
      wait_cnt  <= 4'h0;
    end else if (mem_req && !mem_ack && wait_cnt >= delay) begin
      mem_ack    <= 1'b1;
      mem_exc    <= fault;
      mem_rdata  <= rd_val;
      wait_cnt   <= 4'h0;
      seen_addr  <= mem_addr;
      seen_wdata <= mem_wdata;
      seen_ctl   <= {mem_we, mem_alloc, mem_size};
    end else begin
      mem_ack   <= 1'b0;
      mem_exc   <= ~mem_exc;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= (mem_req && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/csmm_exec.sv ====
`default_nettype none
module csmm_exec
  import csmm_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        issue_valid,
  input  wire logic [15:0] issue_opcode,
  input  wire logic [31:0] issue_pc,
  input  wire logic        issue_in_slot,
  output logic             issue_ready,
  output logic             mem_req,
  output logic             mem_we,
  output logic [1:0]       mem_size,
  output logic             mem_alloc,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire logic [2:0]  mem_exc,
  output logic             done,
  output logic             exc_valid,
  output logic [2:0]       exc_code,
  output logic [31:0]      pc_out,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);
  import csmm_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    csmm_state_t          state;
    logic [15:0][31:0]    gpr;
    logic [31:0]          mul_lo;
    logic [31:0]          mul_hi;
    logic [31:0]          pc;
    logic [1:0]           ctrl;
    logic [EV_W-1:0]      sts;
    logic [EV_W-1:0]      mask;
    csmm_kind_t           kind;
    logic [3:0]           dst;
    logic [31:0]          ipc;
    logic                 zero_pend;
    logic [2:0]           mul_cnt;
    logic [31:0]          mul_res;
    logic                 ready;
    logic                 req;
    logic                 we;
    logic [1:0]           size;
    logic                 alloc;
    logic [31:0]          addr;
    logic [31:0]          wdata;
    logic                 done;
    logic                 exc_valid;
    logic [2:0]           exc_code;
    logic [31:0]          rdata;
    logic                 irq;
  } csmm_regs_t;

  csmm_regs_t r_reg;
  csmm_regs_t r_next;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic csmm_kind_t decode(input logic [15:0] op);
    csmm_kind_t k;
    k = K_NONE;
    case (op[15:12])
      4'h1: k = K_LST;
      4'h5: k = K_LLD;
      4'h8: begin
        case (op[11:8])
          4'h0:    k = K_BST;
          4'h1:    k = K_WST;
          4'h4:    k = K_BLD;
          4'h5:    k = K_WLD;
          default: k = K_NONE;
        endcase
      end
      4'hc: k = (op[11:8] == 4'h7) ? K_EAL : K_NONE;
      4'h0: begin
        if (op[7:0] == 8'hc3) begin
          k = K_CAS;
        end else if (op[7:0] == 8'h29) begin
          k = K_FLAG;
        end else if (op[3:0] == 4'h7) begin
          k = K_MULL;
        end
      end
      4'h2: k = (op[3:0] == 4'hf) ? K_MULS : K_NONE;
      default: k = K_NONE;
    endcase
    return k;
  endfunction

  csmm_kind_t  dk;
  logic [3:0]  fn;
  logic [3:0]  fm;
  logic [31:0] d4;
  logic        reads_r0;
  logic        issue_fire;
  logic [63:0] prod_l;
  logic signed [31:0] prod_w;

  always_comb begin
    dk = decode(issue_opcode);
    fn = issue_opcode[11:8];
    fm = issue_opcode[7:4];
    d4 = {28'h0, issue_opcode[3:0]};
    // byte/word stores and many others read register_zero
    reads_r0 = (dk == K_BST) || (dk == K_WST) || (dk == K_CAS)
             || (fn == 4'h0) || (fm == 4'h0);
    issue_fire = issue_valid && r_reg.ready
               && !(r_reg.zero_pend && reads_r0);
    prod_l = 64'(r_reg.gpr[fn]) * 64'(r_reg.gpr[fm]);
    prod_w = $signed(r_reg.gpr[fn][15:0]) *
             $signed(r_reg.gpr[fm][15:0]);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] clr;

  always_comb begin
    r_next = r_reg;
    ev = '0;
    clr = '0;
    r_next.done = 1'b0;
    r_next.exc_valid = 1'b0;
    r_next.rdata = 32'h0;
    // register bus
    if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL:   r_next.ctrl = reg_wdata[1:0];
        OFF_STATUS: clr = reg_wdata[EV_W-1:0];
        OFF_MASK:   r_next.mask = reg_wdata[EV_W-1:0];
        OFF_PC:     r_next.pc = reg_wdata;
        OFF_MUL_LO: r_next.mul_lo = reg_wdata;
        OFF_MUL_HI: r_next.mul_hi = reg_wdata;
        default: begin
          if (reg_addr[7:6] == OFF_GPR[7:6] && reg_addr[1:0] == 2'h0) begin
            r_next.gpr[reg_addr[5:2]] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFF_CTRL:   r_next.rdata = {30'h0, r_reg.ctrl};
        OFF_STATUS: r_next.rdata = {28'h0, r_reg.sts};
        OFF_MASK:   r_next.rdata = {28'h0, r_reg.mask};
        OFF_PC:     r_next.rdata = r_reg.pc;
        OFF_MUL_LO: r_next.rdata = r_reg.mul_lo;
        OFF_MUL_HI: r_next.rdata = r_reg.mul_hi;
        default: begin
          if (reg_addr[7:6] == OFF_GPR[7:6] && reg_addr[1:0] == 2'h0) begin
            r_next.rdata = r_reg.gpr[reg_addr[5:2]];
          end
        end
      endcase
    end
    // execution
    case (r_reg.state)
      S_IDLE: begin
        r_next.ready = r_reg.ctrl[CTRL_EN];
        if (issue_fire) begin
          r_next.kind = dk;
          r_next.ipc = issue_pc;
          r_next.ready = 1'b0;
          case (dk)
            K_BST, K_WST, K_LST, K_BLD, K_WLD, K_LLD, K_CAS: begin
              r_next.state = S_MEM;
              r_next.req = 1'b1;
              r_next.alloc = 1'b0;
              r_next.we = 1'b0;
              r_next.dst = 4'h0;
              case (dk)
                K_BST: begin
                  r_next.we = 1'b1;
                  r_next.size = SZ_BYTE;
                  r_next.addr = r_reg.gpr[fm] + d4;
                  r_next.wdata = r_reg.gpr[0];
                end
                K_WST: begin
                  r_next.we = 1'b1;
                  r_next.size = SZ_WORD;
                  r_next.addr = r_reg.gpr[fm] + (d4 << 1);
                  r_next.wdata = r_reg.gpr[0];
                end
                K_LST: begin
                  r_next.we = 1'b1;
                  r_next.size = SZ_LONG;
                  r_next.addr = r_reg.gpr[fn] + (d4 << 2);
                  r_next.wdata = r_reg.gpr[fm];
                end
                K_BLD: begin
                  r_next.size = SZ_BYTE;
                  r_next.addr = r_reg.gpr[fm] + d4;
                  r_next.zero_pend = 1'b1;
                end
                K_WLD: begin
                  r_next.size = SZ_WORD;
                  r_next.addr = r_reg.gpr[fm] + (d4 << 1);
                  r_next.zero_pend = 1'b1;
                end
                K_LLD: begin
                  r_next.size = SZ_LONG;
                  r_next.addr = r_reg.gpr[fm] + (d4 << 2);
                  r_next.dst = fn;
                end
                default: begin
                  // allocating store; cache allocates without fill
                  r_next.we = 1'b1;
                  r_next.alloc = 1'b1;
                  r_next.size = SZ_LONG;
                  r_next.addr = r_reg.gpr[fn];
                  r_next.wdata = r_reg.gpr[0];
                end
              endcase
            end
            K_EAL: begin
              if (issue_in_slot) begin
                ev[EV_SLOT] = 1'b1;
                r_next.exc_valid = 1'b1;
                r_next.exc_code = EXC_SLOT;
              end else begin
                r_next.gpr[0] = {issue_pc[31:2], 2'b00} + PC_AHEAD
                  + {22'h0, issue_opcode[7:0], 2'b00};
                r_next.pc = issue_pc + PC_STEP;
                r_next.done = 1'b1;
                ev[EV_DONE] = 1'b1;
              end
            end
            K_FLAG: begin
              r_next.gpr[fn] = {31'h0, r_reg.ctrl[CTRL_T]};
              r_next.pc = issue_pc + PC_STEP;
              r_next.done = 1'b1;
              ev[EV_DONE] = 1'b1;
            end
            K_MULL: begin
              r_next.state = S_MUL;
              r_next.mul_res = prod_l[31:0];
              r_next.mul_cnt = 3'(MUL_LONG_STATES - 1);
            end
            K_MULS: begin
              r_next.state = S_MUL;
              r_next.mul_res = prod_w;
              r_next.mul_cnt = 3'(MUL_WORD_STATES - 1);
            end
            default: begin
              ev[EV_UNDEF] = 1'b1;
              r_next.pc = issue_pc + PC_STEP;
              r_next.done = 1'b1;
            end
          endcase
        end
      end
      S_MEM: begin
        if (mem_ack) begin
          r_next.req = 1'b0;
          r_next.alloc = 1'b0;
          r_next.zero_pend = 1'b0;
          r_next.state = S_IDLE;
          r_next.ready = r_reg.ctrl[CTRL_EN];
          if (mem_exc != EXC_NONE) begin
            ev[EV_MEMX] = 1'b1;
            r_next.exc_valid = 1'b1;
            r_next.exc_code = mem_exc;
          end else begin
            case (r_reg.kind)
              K_BLD: r_next.gpr[0] =
                {{24{mem_rdata[7]}}, mem_rdata[7:0]};
              K_WLD: r_next.gpr[0] =
                {{16{mem_rdata[15]}}, mem_rdata[15:0]};
              K_LLD: r_next.gpr[r_reg.dst] = mem_rdata;
              default: r_next.gpr[0] = r_next.gpr[0];
            endcase
            r_next.pc = r_reg.ipc + PC_STEP;
            r_next.done = 1'b1;
            ev[EV_DONE] = 1'b1;
          end
        end
      end
      S_MUL: begin
        if (r_reg.mul_cnt == 3'h1) begin
          r_next.mul_lo = r_reg.mul_res;
          r_next.pc = r_reg.ipc + PC_STEP;
          r_next.done = 1'b1;
          ev[EV_DONE] = 1'b1;
          r_next.state = S_IDLE;
          r_next.ready = r_reg.ctrl[CTRL_EN];
        end
        r_next.mul_cnt = r_reg.mul_cnt - 3'h1;
      end
      default: begin
        r_next.state = S_IDLE;
        r_next.ready = 1'b0;
      end
    endcase
    // events win over software clear
    r_next.sts = (r_reg.sts & ~clr) | ev;
    r_next.irq = |(r_next.sts & r_next.mask);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
      r_reg.state <= S_IDLE;
      r_reg.ctrl <= CTRL_RST;
      r_reg.kind <= K_NONE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign issue_ready = r_reg.ready;
  assign mem_req     = r_reg.req;
  assign mem_we      = r_reg.we;
  assign mem_size    = r_reg.size;
  assign mem_alloc   = r_reg.alloc;
  assign mem_addr    = r_reg.addr;
  assign mem_wdata   = r_reg.wdata;
  assign done        = r_reg.done;
  assign exc_valid   = r_reg.exc_valid;
  assign exc_code    = r_reg.exc_code;
  assign pc_out      = r_reg.pc;
  assign reg_rdata   = r_reg.rdata;
  assign irq         = r_reg.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_byte_addr_form: assert property (issue_fire && dk == K_BLD |=>
    mem_addr == $past(r_reg.gpr[fm]) + {28'h0, $past(issue_opcode[3:0])}
    && mem_size == SZ_BYTE)
    else $error("byte address wrong");
  a_long_addr_form: assert property (issue_fire && dk == K_LST |=>
    mem_addr == $past(r_reg.gpr[fn])
    + {26'h0, $past(issue_opcode[3:0]), 2'b00}
    && mem_wdata == $past(r_reg.gpr[fm]))
    else $error("long address wrong");
  a_word_sext: assert property (r_reg.state == S_MEM && mem_ack
    && mem_exc == EXC_NONE && r_reg.kind == K_WLD |=>
    r_reg.gpr[0] == {{16{$past(mem_rdata[15])}}, $past(mem_rdata[15:0])})
    else $error("word load not sign extended");
  a_zero_interlock: assert property (r_reg.zero_pend |-> !issue_ready)
    else $error("issue while zero load pending");
  a_eal_value: assert property (issue_fire && dk == K_EAL
    && !issue_in_slot && !reg_wr |=> r_reg.gpr[0] ==
    {$past(issue_pc[31:2]), 2'b00} + 32'h4
    + {22'h0, $past(issue_opcode[7:0]), 2'b00} && done)
    else $error("address load value wrong");
  a_slot_trap: assert property (issue_fire && dk == K_EAL && issue_in_slot
    |=> exc_valid && exc_code == EXC_SLOT && !done
    && $stable(r_reg.pc))
    else $error("slot exception missing");
  a_alloc_store: assert property (mem_req && r_reg.kind == K_CAS |->
    mem_we && mem_alloc && mem_size == SZ_LONG)
    else $error("allocating store malformed");
  a_flag_move: assert property (issue_fire && dk == K_FLAG && !reg_wr |=>
    r_reg.gpr[$past(fn)] == {31'h0, $past(r_reg.ctrl[CTRL_T])})
    else $error("flag move wrong");
  a_mul_latency: assert property (issue_fire && dk == K_MULL |=>
    !done ##1 !done ##1 done)
    else $error("multiply latency wrong");
  a_mul_hi_kept: assert property (!(reg_wr && reg_addr == OFF_MUL_HI) |=>
    $stable(r_reg.mul_hi))
    else $error("multiply high changed");
  a_pc_step: assert property (r_reg.state == S_MUL && r_reg.mul_cnt == 3'h1
    && !reg_wr |=> pc_out == r_reg.ipc + 32'h2)
    else $error("pc not advanced");

  c_byte_load:  cover property (issue_fire && dk == K_BLD ##[1:20] done);
  c_stall:      cover property (r_reg.zero_pend && issue_valid);
  c_mem_fault:  cover property (exc_valid && exc_code == EXC_TLBM);
  c_word_mul:   cover property (issue_fire && dk == K_MULS ##2 done);
endmodule
`default_nettype wire

// ==== rtl/csmm_pkg.sv ====
`default_nettype none
package csmm_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_PC     = 8'h0c;
  localparam logic [7:0] OFF_MUL_LO = 8'h10;
  localparam logic [7:0] OFF_MUL_HI = 8'h14;
  localparam logic [7:0] OFF_GPR    = 8'h40;
  localparam int         CTRL_EN    = 0;
  localparam int         CTRL_T     = 1;
  localparam logic [1:0] CTRL_RST   = 2'h1;
  // ----------------------------------------
  // status / mask bits
  // ----------------------------------------
  localparam int EV_DONE  = 0;
  localparam int EV_SLOT  = 1;
  localparam int EV_MEMX  = 2;
  localparam int EV_UNDEF = 3;
  localparam int EV_W     = 4;
  // ----------------------------------------
  // exception codes
  // ----------------------------------------
  localparam logic [2:0] EXC_NONE  = 3'h0;
  localparam logic [2:0] EXC_TLBM  = 3'h1;
  localparam logic [2:0] EXC_PROT  = 3'h2;
  localparam logic [2:0] EXC_IPW   = 3'h3;
  localparam logic [2:0] EXC_ADDR  = 3'h4;
  localparam logic [2:0] EXC_SLOT  = 3'h5;
  // ----------------------------------------
  // access sizes and timing
  // ----------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam int MUL_LONG_STATES = 3;
  localparam int MUL_WORD_STATES = 2;
  localparam logic [31:0] PC_STEP  = 32'h2;
  localparam logic [31:0] PC_AHEAD = 32'h4;
  // ----------------------------------------
  // operation kinds and states
  // ----------------------------------------
  typedef enum logic [3:0] {
    K_NONE, K_BST, K_WST, K_LST, K_BLD, K_WLD, K_LLD,
    K_EAL, K_CAS, K_FLAG, K_MULL, K_MULS
  } csmm_kind_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_MEM  = 4'b0010,
    S_MUL  = 4'b0100,
    S_RSVD = 4'b1000
  } csmm_state_t;
endpackage
`default_nettype wire
